// ==== sim/isq_ctrl_model.sv ====
// behavioural protocol controller: message strobes and self-test flag
`timescale 1ns/100ps
module isq_ctrl_model
  import isq_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              go,
  input  wire logic              chip_select,
  input  wire logic              write_strobe,
  input  wire logic              read_strobe,
  input  wire logic [ADDR_W-1:0] reg_addr,
  output logic                   ctl_rd,
  output logic                   ctl_wr,
  output logic                   msg,
  output logic                   flag
);
  int cnt  = 0;
  int busy = 0;
  int c;
  logic [15:0] rom  [0:511];
  logic [15:0] regs [0:31];
  // bit toggles while not read, so a stale level never looks valid
  assign flag = read_strobe ? (busy != 0) : mclk;
  initial begin
    ctl_rd = 0;
    ctl_wr = 0;
    msg = 0;
    rom[9'h1e0] = 16'h0181;
    rom[9'h1ee] = 16'h2000;
    rom[9'h1f0] = 16'h0001;
  end
  always @(posedge mclk) begin
    c = (cnt != 0 || go) ? (cnt + 1) % 8 : 0;
    #1;
    cnt = c;
    ctl_rd = cnt inside {1, 2, 5};
    ctl_wr = cnt == 4;
    // upper rom address lines float high during configuration writes
    if (chip_select && write_strobe) regs[reg_addr] = rom[{4'hf, reg_addr}];
    msg = cnt inside {[3:6]};
    if (chip_select && write_strobe && reg_addr == REG_SELF_TEST) busy = 4;
    else if (busy != 0) busy = busy - 1;
  end
endmodule // isq_ctrl_model

// ==== sim/isq_init_sequencer_tb.sv ====
// self-checking bench for the init sequencer
`timescale 1ns/100ps
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module isq_init_sequencer_tb
  import isq_pkg::*;
;
  logic              mclk = 0, nrst = 1, st_req = 0, mon = 0, go = 0;
  logic              ctl_rd, ctl_wr, msg, flag, cs, wr, rd, rom, oqr, iqw;
  logic [ADDR_W-1:0] addr, oe;
  int                err_total = 0, n_compared = 0, cyc = 0;

  always #5 mclk = ~mclk;

  isq_init_sequencer isq_init_sequencer_i (.mclk(mclk), .nrst(nrst),
    .self_test_req(st_req), .terminal_or_monitor_select(mon), .test_running_flag(flag),
    .controller_read_strobe(ctl_rd), .controller_write_strobe(ctl_wr),
    .message_active_strobe(msg), .chip_select(cs), .write_strobe(wr), .read_strobe(rd),
    .config_rom_enable(rom), .outgoing_queue_read(oqr), .incoming_queue_write(iqw),
    .reg_addr(addr), .reg_addr_oe(oe));

  isq_ctrl_model isq_ctrl_model_i (.mclk(mclk), .go(go), .chip_select(cs),
    .write_strobe(wr), .read_strobe(rd), .reg_addr(addr), .ctl_rd(ctl_rd), .ctl_wr(ctl_wr),
    .msg(msg), .flag(flag));

  // expected outputs for a state code, fifo strobes from live controller strobes
  function automatic logic [15:0] ex(input logic [3:0] s);
    logic              w, r, q;
    logic [ADDR_W-1:0] a;
    w = s inside {4'h1, 4'h9, 4'he, 4'h5};
    r = s == 4'h6;
    q = s == 4'h2;
    a = s inside {4'h0, 4'h1, 4'h3} ? 5'h10 : s inside {4'hb, 4'h9, 4'hd} ? 5'h0e :
        s inside {4'h7, 4'h5, 4'h4} ? 5'h0b : r ? 5'h01 : 5'h00;
    return {w | r, w, r, !(s inside {4'h8, 4'h2, 4'h6}),
            s inside {4'h8, 4'ha, 4'h2} ? 5'h00 : 5'h1f, a, q & ctl_wr, q & ctl_rd};
  endfunction

  task ck(input logic [3:0] s);
    `CMP({cs, wr, rd, rom, oe, addr, iqw, oqr}, ex(s))
  endtask

  // one state per cycle, starting and ending just after an edge
  task walk(input logic [39:0] q, input int n);
    for (int i = 0; i < n; i++) begin
      #1;
      ck(q[4 * (n - 1 - i) +: 4]);
      @(posedge mclk);
      #1;
    end
  endtask

  task rst(input logic t, input logic m);
    nrst = 0;
    st_req = t;
    mon = m;
    #1;
    ck(4'h0);
    repeat (10) @(posedge mclk);
    #1 nrst = 1;
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      err_total++;
      test_done;
    end
  end

  initial begin
    @(posedge mclk);
    #1;
    rst(0, 0);
    walk(40'h013fec8888, 10);
    `CMP(isq_ctrl_model_i.regs[0], 16'h0181)
    `CMP(isq_ctrl_model_i.regs[16], 16'h0001)
    go = 1;
    @(posedge mclk);
    #1 go = 0;
    walk(40'h8aa22228, 8);
    rst(0, 1);
    walk(40'h013b9dfec8, 10);
    `CMP(isq_ctrl_model_i.regs[14], 16'h2000)
    rst(1, 0);
    walk(40'h013754666, 9);
    st_req = 0;
    walk(40'h3fec8, 5);
    test_done;
  end
endmodule // isq_init_sequencer_tb

// ==== verilog/isq_init_sequencer.sv ====
// init sequencer that configures the protocol controller and gates its fifos
`timescale 1ns/100ps

// Summary of operation
// RQ1: single clock, state inputs sampled synchronously, controller strobes gate fifo strobes unclocked; nrst clears the state register asynchronously
// RQ2: two-state strobes, three-state five-bit address
// RQ3: address floats whenever address drive is off
// RQ4: fifo strobes are queue mode and controller strobes
// RQ5: queue mode only in message-transfer state
// RQ6: codes 0000,0001,0011 write address 10 hex
// RQ7: branch on self-test request and terminal/monitor
// RQ8: monitor setup writes register 0E, then enable
// RQ9: enable states write register 00, then wait
// RQ10: wait releases bus until controller read strobe
// RQ11: fetch enables rom, held while read strobe
// RQ12: transfer holds while message strobe, then wait
// RQ13: self-test states write 0B, then poll
// RQ14: poll register 01 until running flag clears
// RQ15: self-test branch may be left out
// RQ16: positive logic, registered state, decoded outputs
// RQ17: rom holds fixed configuration constants
// RQ18: controller reads control word, holds message strobe
// RQ19: reset forces state 0000
// RQ20: undriven upper rom address lines pulled high
module isq_init_sequencer
  import isq_pkg::*;
#(
  parameter bit SELF_TEST_EN = 1'b1
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              self_test_req,
  input  wire logic              terminal_or_monitor_select,
  input  wire logic              test_running_flag,
  input  wire logic              controller_read_strobe,
  input  wire logic              controller_write_strobe,
  input  wire logic              message_active_strobe,
  output logic                   chip_select,
  output logic                   write_strobe,
  output logic                   read_strobe,
  output logic                   config_rom_enable,
  output logic                   outgoing_queue_read,
  output logic                   incoming_queue_write,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [ADDR_W-1:0]      reg_addr_oe
);

  isq_regs_s   state_reg;
  isq_regs_s   state_next;
  isq_decode_s dec;

  // outputs for a given state, decoded from the state bits alone
  function automatic isq_decode_s decode_state(input isq_state_e st);
    isq_decode_s d;
    d = '{rom_en: 1'b1, cs: 1'b0, wr: 1'b0, rd: 1'b0, adr_en: 1'b1,
          queue: 1'b0, addr: ADDR_PARKED};
    case (st)
      ST_CFG_SETUP, ST_BRANCH: begin
        d.addr = REG_MON_ADDR; // RQ6
      end
      ST_CFG_WRITE: begin
        d.addr = REG_MON_ADDR; // RQ6
        d.cs   = 1'b1;
        d.wr   = 1'b1;
      end
      ST_MON_SETUP, ST_MON_HOLD: begin
        d.addr = REG_MON_CFG; // RQ8
      end
      ST_MON_WRITE: begin
        d.addr = REG_MON_CFG; // RQ8
        d.cs   = 1'b1;
        d.wr   = 1'b1;
      end
      ST_EN_SETUP, ST_EN_HOLD: begin
        d.addr = REG_ENABLE; // RQ9
      end
      ST_EN_WRITE: begin
        d.addr = REG_ENABLE; // RQ9
        d.cs   = 1'b1;
        d.wr   = 1'b1;
      end
      ST_WAIT: begin
        d.rom_en = 1'b0; // RQ10
        d.adr_en = 1'b0;
      end
      ST_FETCH: begin
        d.adr_en = 1'b0; // RQ11
      end
      ST_XFER: begin
        d.rom_en = 1'b0; // RQ12
        d.adr_en = 1'b0;
        d.queue  = 1'b1; // RQ5
      end
      ST_BIT_SETUP, ST_BIT_HOLD: begin
        d.addr = REG_SELF_TEST; // RQ13
      end
      ST_BIT_WRITE: begin
        d.addr = REG_SELF_TEST; // RQ13
        d.cs   = 1'b1;
        d.wr   = 1'b1;
      end
      ST_POLL: begin
        d.rom_en = 1'b0; // RQ14
        d.addr   = REG_STATUS;
        d.cs     = 1'b1;
        d.rd     = 1'b1;
      end
      default: begin
        d.addr = ADDR_PARKED;
      end
    endcase
    return d;
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg.st)
      ST_CFG_SETUP: state_next.st = ST_CFG_WRITE; // RQ6
      ST_CFG_WRITE: state_next.st = ST_BRANCH;
      ST_BRANCH: begin
        if (SELF_TEST_EN && self_test_req) begin
          state_next.st = ST_BIT_SETUP; // RQ7 RQ15
        end else if (terminal_or_monitor_select) begin
          state_next.st = ST_MON_SETUP; // RQ7
        end else begin
          state_next.st = ST_EN_SETUP; // RQ7
        end
      end
      ST_MON_SETUP: state_next.st = ST_MON_WRITE; // RQ8
      ST_MON_WRITE: state_next.st = ST_MON_HOLD;
      ST_MON_HOLD:  state_next.st = ST_EN_SETUP;
      ST_EN_SETUP:  state_next.st = ST_EN_WRITE; // RQ9
      ST_EN_WRITE:  state_next.st = ST_EN_HOLD;
      ST_EN_HOLD:   state_next.st = ST_WAIT;
      ST_WAIT: begin
        if (controller_read_strobe) begin
          state_next.st = ST_FETCH; // RQ10 RQ18
        end
      end
      ST_FETCH: begin
        if (!controller_read_strobe) begin
          state_next.st = ST_XFER; // RQ11
        end
      end
      ST_XFER: begin
        if (!message_active_strobe) begin
          state_next.st = ST_WAIT; // RQ12 RQ18
        end
      end
      ST_BIT_SETUP: state_next.st = ST_BIT_WRITE; // RQ13
      ST_BIT_WRITE: state_next.st = ST_BIT_HOLD;
      ST_BIT_HOLD:  state_next.st = ST_POLL;
      ST_POLL: begin
        if (!test_running_flag) begin
          state_next.st = ST_BRANCH; // RQ14
        end
      end
      default: state_next.st = RESET_STATE;
    endcase
  end

  // only the four state bits are stored
  always_ff @(posedge mclk or negedge nrst) begin // RQ1 RQ16
    if (!nrst) begin
      state_reg.st <= RESET_STATE; // RQ19
    end else begin
      state_reg <= state_next;
    end
  end

  assign dec = decode_state(state_reg.st); // RQ16

  // strobes decoded from the state bits, fifo strobes gated through
  always_comb begin
    chip_select          = dec.cs; // RQ2
    write_strobe         = dec.wr;
    read_strobe          = dec.rd;
    config_rom_enable    = dec.rom_en;
    outgoing_queue_read  = dec.queue & controller_read_strobe; // RQ4
    incoming_queue_write = dec.queue & controller_write_strobe; // RQ4
    // parked at zero while floating; board pull-ups set upper rom lines
    reg_addr    = dec.adr_en ? dec.addr : ADDR_PARKED; // RQ3 RQ20
    reg_addr_oe = {ADDR_W{dec.adr_en}}; // RQ2 RQ3
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_cfg_write_seq: assert property ( // RQ6
    state_reg.st == ST_CFG_SETUP |=> state_reg.st == ST_CFG_WRITE && chip_select
      && write_strobe && reg_addr == REG_MON_ADDR ##1 state_reg.st == ST_BRANCH)
    else $error("monitor address write sequence broken");

  a_branch_self_test: assert property ( // RQ7
    state_reg.st == ST_BRANCH && self_test_req && SELF_TEST_EN
      |=> state_reg.st == ST_BIT_SETUP)
    else $error("self-test branch not taken");

  a_branch_mode: assert property ( // RQ7
    state_reg.st == ST_BRANCH && !(self_test_req && SELF_TEST_EN)
      |=> state_reg.st == ($past(terminal_or_monitor_select) ? ST_MON_SETUP : ST_EN_SETUP))
    else $error("terminal or monitor branch wrong");

  a_monitor_setup: assert property ( // RQ8
    state_reg.st == ST_MON_SETUP |=> chip_select && reg_addr == REG_MON_CFG
      ##1 !chip_select && reg_addr == REG_MON_CFG ##1 state_reg.st == ST_EN_SETUP)
    else $error("monitor setup sequence broken");

  a_enable_write: assert property ( // RQ9
    state_reg.st == ST_EN_SETUP |=> write_strobe && reg_addr == REG_ENABLE
      ##1 !write_strobe ##1 state_reg.st == ST_WAIT)
    else $error("enable write sequence broken");

  a_wait_release: assert property ( // RQ10
    state_reg.st == ST_WAIT |-> !config_rom_enable && reg_addr_oe == '0
      ##1 state_reg.st == ($past(controller_read_strobe) ? ST_FETCH : ST_WAIT))
    else $error("wait state misbehaves");

  a_fetch_hold: assert property ( // RQ11
    state_reg.st == ST_FETCH |-> config_rom_enable && reg_addr_oe == '0
      ##1 state_reg.st == ($past(controller_read_strobe) ? ST_FETCH : ST_XFER))
    else $error("control word fetch misbehaves");

  a_xfer_exit: assert property ( // RQ12
    state_reg.st == ST_XFER && !message_active_strobe |=> state_reg.st == ST_WAIT)
    else $error("transfer did not end on message strobe drop");

  a_queue_gating: assert property ( // RQ4 RQ5
    (incoming_queue_write || outgoing_queue_read) |-> state_reg.st == ST_XFER
      && (incoming_queue_write == controller_write_strobe)
      && (outgoing_queue_read == controller_read_strobe))
    else $error("fifo strobe outside transfer state");

  a_self_test_start: assert property ( // RQ13
    state_reg.st == ST_BIT_SETUP |=> write_strobe && reg_addr == REG_SELF_TEST
      ##1 !chip_select ##1 state_reg.st == ST_POLL)
    else $error("self-test start sequence broken");

  a_poll_exit: assert property ( // RQ14
    state_reg.st == ST_POLL |-> read_strobe && chip_select && reg_addr == REG_STATUS
      ##1 state_reg.st == ($past(test_running_flag) ? ST_POLL : ST_BRANCH))
    else $error("status poll misbehaves");

  c_monitor_path:  cover property (state_reg.st == ST_MON_HOLD ##1 state_reg.st == ST_EN_SETUP);
  c_message_done:  cover property (state_reg.st == ST_XFER ##1 state_reg.st == ST_WAIT);
  c_queue_write:   cover property (incoming_queue_write);
  c_self_test_end: cover property (state_reg.st == ST_POLL ##1 state_reg.st == ST_BRANCH);

endmodule // isq_init_sequencer

// ==== verilog/isq_pkg.sv ====
// shared types and constants for the stand-alone controller init sequencer
package isq_pkg;

  localparam int unsigned ADDR_W = 5;

  // controller register addresses driven during configuration
  localparam logic [ADDR_W-1:0] REG_MON_ADDR  = 5'h10;
  localparam logic [ADDR_W-1:0] REG_MON_CFG   = 5'h0e;
  localparam logic [ADDR_W-1:0] REG_ENABLE    = 5'h00;
  localparam logic [ADDR_W-1:0] REG_SELF_TEST = 5'h0b;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_PARKED   = 5'h00;

  // state codes are the four registered state bits A,B,C,D
  typedef enum logic [3:0] {
    ST_CFG_SETUP = 4'h0,
    ST_CFG_WRITE = 4'h1,
    ST_BRANCH    = 4'h3,
    ST_MON_SETUP = 4'hb,
    ST_MON_WRITE = 4'h9,
    ST_MON_HOLD  = 4'hd,
    ST_EN_SETUP  = 4'hf,
    ST_EN_WRITE  = 4'he,
    ST_EN_HOLD   = 4'hc,
    ST_WAIT      = 4'h8,
    ST_FETCH     = 4'ha,
    ST_XFER      = 4'h2,
    ST_BIT_SETUP = 4'h7,
    ST_BIT_WRITE = 4'h5,
    ST_BIT_HOLD  = 4'h4,
    ST_POLL      = 4'h6
  } isq_state_e;

  localparam isq_state_e RESET_STATE = ST_CFG_SETUP;

  typedef struct packed {
    isq_state_e st;
  } isq_regs_s;

  // decoded strobes and address for one state
  typedef struct packed {
    logic              rom_en;
    logic              cs;
    logic              wr;
    logic              rd;
    logic              adr_en;
    logic              queue;
    logic [ADDR_W-1:0] addr;
  } isq_decode_s;

endpackage
